// ==== core/ibc_bus_control.sv ====
// bus control register, line monitor, line forcing, extra clock and resets
// assumes apb master on pclk and open-drain pads resolved outside
// How it works
// RULE1 - data monitor bit shows real data line
// RULE2 - clock monitor bit shows real clock line
// RULE3 - data output bit pulls or releases data
// RULE4 - clock output bit pulls or releases clock
// RULE5 - guard zero enables output bit writes; reads one
// RULE6 - extra clock bit emits one pulse, self-clears
// RULE7 - software keeps extra clock off during transfers
// RULE8 - reset with enable low resets everything
// RULE9 - reset with enable high resets engine only
// RULE10 - reset holds while bit set; zero releases
// RULE11 - any reset releases both lines, clears counter
// RULE12 - enable bit activates or idles the pins
// RULE13 - forced levels feed back into input path
// RULE14 - software avoids output writes during traffic
// RULE15 - master resynchronises after slave internal reset
// RULE16 - address compare runs while pins routed
// RULE17 - reset request clears condition requests, mode
// RULE18 - single clock, synchronised line sampling
`default_nettype none
module ibc_bus_control
  import ibc_pkg::*;
#(
  parameter int         XC_LOW_CYC  = IBC_XC_LOW_CYC,
  parameter int         XC_HIGH_CYC = IBC_XC_HIGH_CYC,
  parameter logic [6:0] SADDR_RESET = IBC_SADDR_RST
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        pins_routed,
  output var  logic        scl_out,
  output var  logic        scl_oe_n,
  output var  logic        sda_out,
  output var  logic        sda_oe_n
);

  // the extra clock phase counter is ten bits wide
  if (XC_LOW_CYC < 1 || XC_LOW_CYC > 1023 || XC_HIGH_CYC < 1 || XC_HIGH_CYC > 1023)
  begin : g_bad_param
    $error("extra clock phase counts must lie in 1..1023");
  end

  localparam logic [9:0] XC_LOW_LAST  = 10'(XC_LOW_CYC - 1);
  localparam logic [9:0] XC_HIGH_LAST = 10'(XC_HIGH_CYC - 1);

  ibc_line_s   sync1_reg, sync2_reg, sync3_reg, lvl_reg, prev_reg;
  ibc_line_s   sync1_next, sync2_next, sync3_next, lvl_next, prev_next;
  logic        en_reg, rst_reg, xc_reg, cout_reg, dout_reg;
  logic        en_next, rst_next, xc_next, cout_next, dout_next;
  ibc_ctrl2_s  ctrl2_reg, ctrl2_next;
  logic [6:0]  saddr_reg, saddr_next;
  logic [31:0] prdata_reg, prdata_next, rd_word;
  logic        pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [2:0]  bc_reg, bc_next;
  logic [7:0]  shift_reg, shift_next;
  logic        seen_st_reg, seen_st_next, match_reg, match_next;
  logic        seen_sp_reg, seen_sp_next, busy_reg, busy_next;
  logic        first_reg, first_next, xc_done_reg, xc_done_next;
  ibc_xc_e     xstate_reg, xstate_next;
  logic [9:0]  xcnt_reg, xcnt_next;
  logic        scl_oe_n_reg, scl_oe_n_next, sda_oe_n_reg, sda_oe_n_next;
  logic        setup, acc_wr, hit1, hit2, hit_st, hit_sa, wr1;
  logic        start_ev, stop_ev, rise;

  // assertion clock and reset for the checks at the end of the module
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // three-stage line sampling; a level counts once stages two and three agree
  always_comb
  begin
    sync1_next = '{scl: scl_in, sda: sda_in};
    sync2_next = sync1_reg;
    sync3_next = sync2_reg;
    prev_next  = lvl_reg;
    lvl_next.scl = (sync2_reg.scl == sync3_reg.scl) ? sync3_reg.scl : lvl_reg.scl; // RULE18
    lvl_next.sda = (sync2_reg.sda == sync3_reg.sda) ? sync3_reg.sda : lvl_reg.sda; // RULE18
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      sync3_reg <= '1;
      lvl_reg   <= '1;
      prev_reg  <= '1;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      sync3_reg <= sync3_next;
      lvl_reg   <= lvl_next;
      prev_reg  <= prev_next;
    end
  end

  // apb decode; answer comes one cycle after setup
  assign setup  = psel & ~penable;
  assign acc_wr = psel & penable & pready_reg & pwrite;
  assign hit1   = (paddr == IBC_CTRL1_OFS);
  assign hit2   = (paddr == IBC_CTRL2_OFS);
  assign hit_st = (paddr == IBC_STAT_OFS);
  assign hit_sa = (paddr == IBC_SADDR_OFS);
  assign wr1    = acc_wr & hit1;

  // read view; monitors show the pin levels, which include our own drive
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit1)
    begin
      rd_word[IBC_B_DMON]  = lvl_reg.sda;  // RULE1 RULE13
      rd_word[IBC_B_CMON]  = lvl_reg.scl;  // RULE2 RULE13
      rd_word[IBC_B_DOUT]  = dout_reg;     // RULE3
      rd_word[IBC_B_COUT]  = cout_reg;     // RULE4
      rd_word[IBC_B_GUARD] = 1'b1;         // RULE5
      rd_word[IBC_B_XCLK]  = xc_reg;
      rd_word[IBC_B_RST]   = rst_reg;
      rd_word[IBC_B_EN]    = en_reg;
    end
    else if (hit2)
    begin
      rd_word[IBC_B_START]   = ctrl2_reg.start;
      rd_word[IBC_B_RESTART] = ctrl2_reg.restart;
      rd_word[IBC_B_STOP]    = ctrl2_reg.stop;
      rd_word[IBC_B_TRS]     = ctrl2_reg.transmit_receive_flag;
    end
    else if (hit_st)
    begin
      rd_word = {6'h00, busy_reg, seen_sp_reg, 6'h00, match_reg, seen_st_reg, shift_reg, 5'h00, bc_reg};
    end
    else if (hit_sa)
    begin
      rd_word = {25'h0, saddr_reg};
    end
  end

  // register writes, then reset overrides
  always_comb
  begin
    pready_next  = setup;
    pslverr_next = setup & ~(hit1 | hit2 | hit_st | hit_sa);
    prdata_next  = setup ? rd_word : prdata_reg;
    en_next    = en_reg;
    rst_next   = rst_reg;
    xc_next    = xc_done_reg ? 1'b0 : xc_reg;  // RULE6
    cout_next  = cout_reg;
    dout_next  = dout_reg;
    ctrl2_next = ctrl2_reg;
    saddr_next = saddr_reg;
    if (wr1)
    begin
      en_next  = pwdata[IBC_B_EN];    // RULE12
      rst_next = pwdata[IBC_B_RST];   // RULE10
      xc_next  = pwdata[IBC_B_XCLK];  // RULE6
      if (!pwdata[IBC_B_GUARD])       // RULE5
      begin
        dout_next = pwdata[IBC_B_DOUT];  // RULE3
        cout_next = pwdata[IBC_B_COUT];  // RULE4
      end
    end
    if (acc_wr && hit2)
    begin
      ctrl2_next.start   = pwdata[IBC_B_START];
      ctrl2_next.restart = pwdata[IBC_B_RESTART];
      ctrl2_next.stop    = pwdata[IBC_B_STOP];
      ctrl2_next.transmit_receive_flag     = pwdata[IBC_B_TRS];
    end
    if (acc_wr && hit_sa)
      saddr_next = pwdata[6:0];
    // the writing edge itself already clears, so no request escapes
    if (rst_next)
    begin
      dout_next  = IBC_LINE_RELEASED;  // RULE11
      cout_next  = IBC_LINE_RELEASED;  // RULE11
      xc_next    = 1'b0;
      ctrl2_next = '0;                 // RULE17
      if (!en_next)
        saddr_next = SADDR_RESET;      // RULE8
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      en_reg      <= 1'b0;
      rst_reg     <= 1'b0;
      xc_reg      <= 1'b0;
      cout_reg    <= IBC_LINE_RELEASED;
      dout_reg    <= IBC_LINE_RELEASED;
      ctrl2_reg   <= '0;
      saddr_reg   <= SADDR_RESET;
    end
    else
    begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
      en_reg      <= en_next;
      rst_reg     <= rst_next;
      xc_reg      <= xc_next;
      cout_reg    <= cout_next;
      dout_reg    <= dout_next;
      ctrl2_reg   <= ctrl2_next;
      saddr_reg   <= saddr_next;
    end
  end

  // bus events seen from the filtered levels
  assign start_ev = prev_reg.scl & lvl_reg.scl & prev_reg.sda & ~lvl_reg.sda;
  assign stop_ev  = prev_reg.scl & lvl_reg.scl & ~prev_reg.sda & lvl_reg.sda;
  assign rise     = lvl_reg.scl & ~prev_reg.scl;

  // receive engine, extra clock sequencer and pin drive
  always_comb
  begin
    bc_next      = bc_reg;
    shift_next   = shift_reg;
    first_next   = first_reg;
    busy_next    = busy_reg;
    seen_st_next = seen_st_reg;
    match_next   = match_reg;
    seen_sp_next = seen_sp_reg;
    xstate_next  = xstate_reg;
    xcnt_next    = xcnt_reg + 10'h001;
    xc_done_next = 1'b0;
    // write one to clear; a same-cycle event sets again below
    if (acc_wr && hit_st)
    begin
      seen_st_next = seen_st_reg & ~pwdata[IBC_B_SEEN_ST];
      match_next   = match_reg & ~pwdata[IBC_B_MATCH];
      seen_sp_next = seen_sp_reg & ~pwdata[IBC_B_SEEN_SP];
    end
    // runs on routed pins even while disabled
    if (pins_routed)  // RULE16
    begin
      if (start_ev)  // RULE13
      begin
        bc_next      = 3'h0;
        shift_next   = 8'h00;
        first_next   = 1'b1;
        busy_next    = 1'b1;
        seen_st_next = 1'b1;
      end
      else if (stop_ev)
      begin
        busy_next    = 1'b0;
        first_next   = 1'b0;
        seen_sp_next = 1'b1;
      end
      else if (rise)
      begin
        shift_next = {shift_reg[6:0], lvl_reg.sda};
        bc_next    = bc_reg + 3'h1;
        if (bc_reg == 3'h7 && first_reg)
        begin
          first_next = 1'b0;
          if (shift_reg[6:0] == saddr_reg)  // RULE16
            match_next = 1'b1;
        end
      end
    end
    unique case (xstate_reg)
      IBC_XC_IDLE:
      begin
        xcnt_next = 10'h000;
        if (xc_reg && en_reg && !xc_done_reg)  // RULE6
          xstate_next = IBC_XC_LOW;
      end
      IBC_XC_LOW:
        if (xcnt_reg == XC_LOW_LAST)
        begin
          xstate_next = IBC_XC_HIGH;
          xcnt_next   = 10'h000;
        end
      IBC_XC_HIGH:
        if (xcnt_reg == XC_HIGH_LAST)
        begin
          xstate_next  = IBC_XC_IDLE;
          xcnt_next    = 10'h000;
          xc_done_next = 1'b1;  // RULE6
        end
      default:
      begin
        xstate_next = IBC_XC_IDLE;
        xcnt_next   = 10'h000;
      end
    endcase
    // both reset flavours clear the engine; enable loss aborts the pulse
    if (rst_reg || !en_reg)
    begin
      xstate_next  = IBC_XC_IDLE;
      xcnt_next    = 10'h000;
      xc_done_next = 1'b0;
    end
    if (rst_reg)  // RULE9 RULE10
    begin
      bc_next      = 3'h0;  // RULE11
      shift_next   = 8'h00;
      first_next   = 1'b0;
      busy_next    = 1'b0;
      seen_st_next = 1'b0;
      match_next   = 1'b0;
      seen_sp_next = 1'b0;
    end
    // open drain: enable low means pulling the line low
    scl_oe_n_next = ~(en_reg & ~rst_reg & (~cout_reg | (xstate_next == IBC_XC_LOW)));  // RULE4 RULE12
    sda_oe_n_next = ~(en_reg & ~rst_reg & ~dout_reg);  // RULE3 RULE11 RULE12
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bc_reg       <= 3'h0;
      shift_reg    <= 8'h00;
      first_reg    <= 1'b0;
      busy_reg     <= 1'b0;
      seen_st_reg  <= 1'b0;
      match_reg    <= 1'b0;
      seen_sp_reg  <= 1'b0;
      xstate_reg   <= IBC_XC_IDLE;
      xcnt_reg     <= 10'h000;
      xc_done_reg  <= 1'b0;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
    end
    else
    begin
      bc_reg       <= bc_next;
      shift_reg    <= shift_next;
      first_reg    <= first_next;
      busy_reg     <= busy_next;
      seen_st_reg  <= seen_st_next;
      match_reg    <= match_next;
      seen_sp_reg  <= seen_sp_next;
      xstate_reg   <= xstate_next;
      xcnt_reg     <= xcnt_next;
      xc_done_reg  <= xc_done_next;
      scl_oe_n_reg <= scl_oe_n_next;
      sda_oe_n_reg <= sda_oe_n_next;
    end
  end

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe_n = scl_oe_n_reg;
  assign sda_oe_n = sda_oe_n_reg;

  // checks on the driven side
  sequence rd1_ans;
    psel && penable && pready_reg && !pwrite && hit1;
  endsequence

  sequence xc_go;
    xstate_reg == IBC_XC_IDLE && xc_reg && en_reg && !rst_reg && !xc_done_reg;
  endsequence

  data_monitor_a: assert property (rd1_ans |-> prdata_reg[IBC_B_DMON] == $past(lvl_reg.sda)) // RULE1
    else $error("data monitor bit differs from line level");
  clock_monitor_a: assert property (rd1_ans |-> prdata_reg[IBC_B_CMON] == $past(lvl_reg.scl)) // RULE2
    else $error("clock monitor bit differs from line level");
  guard_reads_a: assert property (rd1_ans |-> prdata_reg[IBC_B_GUARD]) // RULE5
    else $error("guard bit read back as zero");
  guard_blocks_a: assert property (wr1 && pwdata[IBC_B_GUARD] && !pwdata[IBC_B_RST] && !rst_reg // RULE5
    |=> dout_reg == $past(dout_reg) && cout_reg == $past(cout_reg))
    else $error("guarded write changed a line output bit");
  data_drive_a: assert property (en_reg && !rst_reg && !dout_reg |=> !sda_oe_n_reg) // RULE3
    else $error("data line not pulled low");
  clock_drive_a: assert property (en_reg && !rst_reg && !cout_reg |=> !scl_oe_n_reg) // RULE4
    else $error("clock line not pulled low");
  extra_pulse_a: assert property (xc_go |=> xstate_reg == IBC_XC_LOW && !scl_oe_n_reg) // RULE6
    else $error("extra clock pulse did not start");
  extra_clear_a: assert property (xc_done_reg && !wr1 |=> !xc_reg ##1 xstate_reg == IBC_XC_IDLE) // RULE6
    else $error("extra clock bit not cleared after pulse");
  full_reset_a: assert property (rst_reg && !en_reg && !(acc_wr && hit_sa) |=> saddr_reg == SADDR_RESET) // RULE8
    else $error("full reset kept a setting register");
  internal_reset_a: assert property (rst_reg && en_reg && !wr1 && !(acc_wr && hit_sa) // RULE9
    |=> bc_reg == 3'h0 && shift_reg == 8'h00 && saddr_reg == $past(saddr_reg))
    else $error("internal reset scope wrong");
  reset_release_a: assert property (rst_reg |=> scl_oe_n_reg && sda_oe_n_reg && !busy_reg) // RULE11
    else $error("lines not released under reset");
  enable_idle_a: assert property (!en_reg |=> scl_oe_n_reg && sda_oe_n_reg) // RULE12
    else $error("pins driven while disabled");
  request_clear_a: assert property (wr1 && pwdata[IBC_B_RST] |=> ctrl2_reg == '0) // RULE17
    else $error("condition requests survived reset request");

endmodule : ibc_bus_control
`default_nettype wire

// ==== shared/ibc_pkg.sv ====
// constants and carrier types for the two-wire bus control block
// assumes a 125 MHz peripheral clock and 32-bit apb addressing
`default_nettype none
package ibc_pkg;

  // register byte addresses
  localparam logic [31:0] IBC_CTRL1_OFS  = 32'h0008_8300;
  localparam logic [31:0] IBC_CTRL2_OFS  = 32'h0008_8304;
  localparam logic [31:0] IBC_STAT_OFS   = 32'h0008_8308;
  localparam logic [31:0] IBC_SADDR_OFS  = 32'h0008_830c;

  // bus_control_one field positions
  localparam int IBC_B_DMON   = 0;
  localparam int IBC_B_CMON   = 1;
  localparam int IBC_B_DOUT   = 2;
  localparam int IBC_B_COUT   = 3;
  localparam int IBC_B_GUARD  = 4;
  localparam int IBC_B_XCLK   = 5;
  localparam int IBC_B_RST    = 6;
  localparam int IBC_B_EN     = 7;

  // control-two and status field positions
  localparam int IBC_B_START    = 1;
  localparam int IBC_B_RESTART  = 2;
  localparam int IBC_B_STOP     = 3;
  localparam int IBC_B_TRS      = 5;
  localparam int IBC_B_SEEN_ST  = 16;
  localparam int IBC_B_MATCH    = 17;
  localparam int IBC_B_SEEN_SP  = 24;

  // values after reset
  localparam logic       IBC_LINE_RELEASED = 1'b1;
  localparam logic [6:0] IBC_SADDR_RST     = 7'h00;

  // extra clock pulse timing
  localparam int IBC_CLK_NS      = 8;
  localparam int IBC_XC_LOW_NS   = 5000;
  localparam int IBC_XC_HIGH_NS  = 5000;
  localparam int IBC_XC_LOW_CYC  = (IBC_XC_LOW_NS + IBC_CLK_NS - 1) / IBC_CLK_NS;
  localparam int IBC_XC_HIGH_CYC = (IBC_XC_HIGH_NS + IBC_CLK_NS - 1) / IBC_CLK_NS;

  typedef struct packed {
    logic scl;
    logic sda;
  } ibc_line_s;

  typedef struct packed {
    logic transmit_receive_flag;
    logic stop;
    logic restart;
    logic start;
  } ibc_ctrl2_s;

  typedef enum logic [2:0] {
    IBC_XC_IDLE = 3'b001,
    IBC_XC_LOW  = 3'b010,
    IBC_XC_HIGH = 3'b100
  } ibc_xc_e;

endpackage : ibc_pkg
`default_nettype wire

// ==== testbench/ibc_line_partner.sv ====
// far side of the two-wire bus: pull-ups plus one other bus master
// assumes the block pulls a line only while its oe_n is low
`default_nettype none
module ibc_line_partner
  import ibc_pkg::*;
#(
  parameter real LINK_NS = 125.0
)(
  input  wire logic      scl_out,
  input  wire logic      scl_oe_n,
  input  wire logic      sda_out,
  input  wire logic      sda_oe_n,
  output var  ibc_line_s line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_low;
  logic sda_low;

  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // wired-and behind pull-ups, so a released line reads high
  always_comb
  begin
    line.scl = (scl_oe_n || scl_out) && !scl_low;
    line.sda = (sda_oe_n || sda_out) && !sda_low;
  end

  // static pulls, used while no frame runs
  task automatic hold(input logic c, input logic d);
    scl_low = c;
    sda_low = d;
  endtask

  // start: data falls with clock high; the clock only runs inside a frame
  task automatic start();
    sda_low = 1'b1;
    #(LINK_NS / 2.0);
    scl_low = 1'b1;
    #(LINK_NS / 2.0);
  endtask

  // one data bit, clock low half then high half
  task automatic send_bit(input logic b);
    sda_low = !b;
    #(LINK_NS / 2.0);
    scl_low = 1'b0;
    #(LINK_NS / 2.0);
    scl_low = 1'b1;
  endtask

  // stop: data rises with clock high, leaving the bus free
  task automatic stop();
    sda_low = 1'b1;
    #(LINK_NS / 2.0);
    scl_low = 1'b0;
    #(LINK_NS / 2.0);
    sda_low = 1'b0;
    #(LINK_NS / 2.0);
  endtask
endmodule // ibc_line_partner
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench for the bus control block
// assumes ibc_pkg and the line partner are compiled first
`default_nettype none
module testbench
  import ibc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int XC = 4; // shortened pulse halves keep the run brief
  localparam logic [7:0] ADDR_BYTE = 8'h54; // seven address bits 0x2a, then a zero
  logic        pclk, presetn, psel, penable, pwrite, pins_routed;
  logic [31:0] paddr, pwdata, prdata, r, seed;
  logic        pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic [1:0]  cur;
  logic [32:0] obs;
  ibc_line_s   line;
  logic [32:0] exp_q[$];
  int          miscompares, compares, n, lw;

  ibc_bus_control #(.XC_LOW_CYC(XC), .XC_HIGH_CYC(XC)) i_ibc_bus_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(line.scl), .sda_in(line.sda), .pins_routed(pins_routed), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  ibc_line_partner i_ibc_line_partner (
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .line(line));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one apb transfer; for reads d is the expected word, noted before the answer
  task automatic apb(input logic is_wr, input logic [31:0] a, input logic [31:0] d, input logic err);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= d;
    if (!is_wr)
      exp_q.push_back({err, d});
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until pready is seen high at a rising edge
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
    begin
      miscompares++;
      wrap_up();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, e, 1'b0);
  endtask

  // pad enables settle one edge after the write edge; checked after two
  task automatic chk_oe(input logic c, input logic d);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("scl_oe_n", {31'h0, c}, {31'h0, scl_oe_n});
    chk("sda_oe_n", {31'h0, d}, {31'h0, sda_oe_n});
  endtask

  // watcher: each completed read is matched with the oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite)
    begin
      if (exp_q.size() == 0)
        chk("unexpected read", 32'h0, 32'h1);
      else
      begin
        obs = exp_q.pop_front();
        chk("prdata", obs[31:0], prdata);
        chk("pslverr", {31'h0, obs[32]}, {31'h0, pslverr});
      end
    end
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pins_routed = 1'b1;
    seed = 32'd8104;
    miscompares = 0;
    compares = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(IBC_CTRL1_OFS, 32'h0000_001f);
    apb(1'b0, 32'h0008_8310, 32'h0, 1'b1);
    wr(32'h0008_8310, 32'h0000_00ff);
    // full reset with the interface disabled
    wr(IBC_CTRL2_OFS, 32'h0000_0022);
    wr(IBC_SADDR_OFS, 32'h0000_0055);
    wr(IBC_CTRL1_OFS, 32'h0000_0080);
    chk_oe(1'b0, 1'b0);
    wr(IBC_CTRL1_OFS, 32'h0000_0000);
    chk_oe(1'b1, 1'b1);
    wr(IBC_CTRL1_OFS, 32'h0000_0040);
    rd(IBC_CTRL2_OFS, 32'h0);
    rd(IBC_SADDR_OFS, 32'h0);
    rd(IBC_CTRL1_OFS, 32'h0000_005f);
    wr(IBC_CTRL1_OFS, 32'h0000_0010);
    rd(IBC_CTRL1_OFS, 32'h0000_001f);
    // a frame from the other master counts bits even while disabled
    i_ibc_line_partner.start();
    for (int b = 0; b < 3; b++)
      i_ibc_line_partner.send_bit(b != 1);
    repeat (8) @(posedge pclk);
    rd(IBC_STAT_OFS, 32'h0201_0503);
    wr(IBC_STAT_OFS, 32'h0001_0000);
    rd(IBC_STAT_OFS, 32'h0200_0503);
    wr(IBC_SADDR_OFS, 32'h0000_002a);
    wr(IBC_CTRL1_OFS, 32'h0000_008c);
    wr(IBC_CTRL2_OFS, 32'h0000_002e);
    rd(IBC_CTRL2_OFS, 32'h0000_002e);
    i_ibc_line_partner.stop();
    // a full address byte that matches the slave address
    i_ibc_line_partner.start();
    for (int b = 7; b >= 0; b--)
      i_ibc_line_partner.send_bit(ADDR_BYTE[b]);
    i_ibc_line_partner.stop();
    rd(IBC_STAT_OFS, 32'h0103_a801);
    // internal reset while both lines are held low
    wr(IBC_CTRL1_OFS, 32'h0000_0080);
    chk_oe(1'b0, 1'b0);
    wr(IBC_CTRL1_OFS, 32'h0000_00d0);
    chk_oe(1'b1, 1'b1);
    rd(IBC_STAT_OFS, 32'h0);
    rd(IBC_SADDR_OFS, 32'h0000_002a);
    rd(IBC_CTRL2_OFS, 32'h0);
    rd(IBC_CTRL1_OFS, 32'h0000_00df);
    wr(IBC_CTRL1_OFS, 32'h0000_0090);
    rd(IBC_CTRL1_OFS, 32'h0000_009f);
    // unrouted pins: the engine ignores the frame
    pins_routed <= 1'b0;
    i_ibc_line_partner.start();
    i_ibc_line_partner.send_bit(1'b1);
    i_ibc_line_partner.stop();
    rd(IBC_STAT_OFS, 32'h0);
    pins_routed <= 1'b1;
    // random forcing, guard and far-side pulls; bus otherwise idle
    cur = 2'b11;
    for (int i = 0; i < 12; i++)
    begin
      r = xorshift();
      i_ibc_line_partner.hold(r[3], r[2]);
      wr(IBC_CTRL1_OFS, {24'h0, 3'b100, r[4], r[1:0], 2'b00});
      if (!r[4])
        cur = r[1:0];
      chk_oe(cur[1], cur[0]);
      repeat (8) @(posedge pclk);
      rd(IBC_CTRL1_OFS, {24'h0, 4'h9, cur, cur[1] & !r[3], cur[0] & !r[2]});
    end
    i_ibc_line_partner.hold(1'b0, 1'b0);
    wr(IBC_CTRL1_OFS, 32'h0000_008c);
    // extra clock pulse on an idle bus
    wr(IBC_CTRL1_OFS, 32'h0000_00ac);
    n = 0;
    while (scl_oe_n !== 1'b0 && n < 20)
    begin
      @(negedge pclk);
      n++;
    end
    lw = 0;
    while (scl_oe_n === 1'b0 && lw < 100)
    begin
      @(negedge pclk);
      lw++;
    end
    chk("pulse low cycles", XC, lw);
    n = 0;
    repeat (2 * XC + 8)
    begin
      @(negedge pclk);
      if (scl_oe_n !== 1'b1)
        n++;
    end
    chk("second pulse", 32'h0, n);
    rd(IBC_CTRL1_OFS, 32'h0000_009f);
    chk("pad values", 32'h0, {30'h0, scl_out, sda_out});
    repeat (4) @(posedge pclk);
    chk("reads left", 32'h0, exp_q.size());
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
